// *** hdl/gpt_pkg.sv ***
// constants and carrier types for the general pin port with timer output
// How it works
// - one control register for four pins, at data address 0x3C.
// - select bit 15 low (reset) leaves pin 3 a plain general pin.
// - select high drives timer pulse on pin 3, ignores its direction, reads back.
// - bits 14-12 and 7-4 are reserved, read as zero, writes ignored.
// - direction bits 11-8: zero input (reset), one output.
// - data bits 3-0 drive output pins; read the sampled level on inputs.
// - sampled pin 2 as input also feeds the branch condition.
// - timer pulse reaches pin 3 only while external select pin is low.
// - 16-bit down counter behind 4-bit prescaler, one step per output clock.
// - counter reaching zero raises timer interrupt and output pulse.
package gpt_pkg;
    localparam logic [15:0] GPT_CTRL_ADDR = 16'h003C;
    localparam int GPT_SEL_BIT = 15;
    localparam int GPT_DIR_LSB = 8;
    localparam int GPT_DAT_LSB = 0;
    localparam int GPT_NPINS = 4;
    localparam int GPT_TIMER_PIN = 3;
    localparam int GPT_BRANCH_PIN = 2;
    localparam logic GPT_SEL_RST = 1'h0;
    localparam logic [3:0] GPT_DIR_RST = 4'h0;
    localparam logic [3:0] GPT_DAT_RST = 4'h0;
    localparam logic [15:0] GPT_PERIOD_RST = 16'hFFFF;
    localparam logic [3:0] GPT_PRESCALE_RST = 4'h0;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } gpt_bus_req_t;

    typedef struct packed {
        logic [3:0] out;
        logic [3:0] oe;
    } gpt_pin_drive_t;
endpackage : gpt_pkg

// *** hdl/gpt_timer.sv ***
// 16-bit down counter with 4-bit prescaler producing the timer pulse
`timescale 1ns/100ps
module gpt_timer #(
    parameter int CNT_W = 16,
    parameter int PSC_W = 4
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic tick_i,
    input wire logic [CNT_W-1:0] period_i,
    input wire logic [PSC_W-1:0] prescale_i,
    output logic pulse_o
);
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [PSC_W-1:0] psc_reg, psc_next;
    logic pulse_reg, pulse_next;

    always_comb begin
        cnt_next = cnt_reg;
        psc_next = psc_reg;
        pulse_next = 1'b0;
        if (tick_i) begin
            if (psc_reg == '0) begin
                psc_next = prescale_i;
                if (cnt_reg == '0) begin
                    cnt_next = period_i;
                end else begin
                    cnt_next = cnt_reg - 1'b1;
                    pulse_next = (cnt_reg == {{(CNT_W-1){1'b0}}, 1'b1});
                end
            end else begin
                psc_next = psc_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= gpt_pkg::GPT_PERIOD_RST;
            psc_reg <= gpt_pkg::GPT_PRESCALE_RST;
            pulse_reg <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            psc_reg <= psc_next;
            pulse_reg <= pulse_next;
        end
    end

    assign pulse_o = pulse_reg;
endmodule : gpt_timer

// *** hdl/gpt_port.sv ***
// four-pin general port with timer output mux and branch condition
`timescale 1ns/100ps
module gpt_port #(
    parameter int NPINS = 4,
    parameter logic [15:0] PERIOD = gpt_pkg::GPT_PERIOD_RST,
    parameter logic [3:0] PRESCALE = gpt_pkg::GPT_PRESCALE_RST
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire gpt_pkg::gpt_bus_req_t bus_i,
    output logic [15:0] rdata_o,
    input wire logic tick_i,
    input wire logic [NPINS-1:0] pin_i,
    output logic [NPINS-1:0] pin_o,
    output logic [NPINS-1:0] pin_oe_o,
    input wire logic external_interface_select_pin_i,
    output logic branch_condition_input_o,
    output logic timer_irq_o
);
    logic timer_output_select_reg, timer_output_select_next;
    logic [NPINS-1:0] pin_direction_bit_reg, pin_direction_bit_next;
    logic [NPINS-1:0] pin_value_bit_reg, pin_value_bit_next;
    logic [NPINS-1:0] sync1_reg, sync2_reg;
    logic ext_sel_sync1_reg, ext_sel_sync2_reg;
    logic [15:0] rdata_reg, rdata_next;
    logic timer_pulse;
    logic timer_on_pin;
    logic hit;
    logic [NPINS-1:0] eff_oe, eff_out, readback;

    gpt_timer #(.CNT_W(16), .PSC_W(4)) u_timer (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .tick_i(tick_i),
        .period_i(PERIOD),
        .prescale_i(PRESCALE),
        .pulse_o(timer_pulse)
    );

    assign timer_irq_o = timer_pulse;
    assign hit = (bus_i.addr == gpt_pkg::GPT_CTRL_ADDR);
    // timer owns pin 3 only in host-port mode
    assign timer_on_pin = timer_output_select_reg & ~ext_sel_sync2_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
            ext_sel_sync1_reg <= 1'h0;
            ext_sel_sync2_reg <= 1'h0;
        end else begin
            sync1_reg <= pin_i;
            sync2_reg <= sync1_reg;
            ext_sel_sync1_reg <= external_interface_select_pin_i;
            ext_sel_sync2_reg <= ext_sel_sync1_reg;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NPINS; g++) begin : g_pin
            if (g == gpt_pkg::GPT_TIMER_PIN) begin : g_tp
                always_comb begin
                    if (timer_output_select_reg) begin
                        eff_oe[g] = timer_on_pin;
                        eff_out[g] = timer_pulse;
                        readback[g] = timer_pulse & timer_on_pin;
                    end else begin
                        eff_oe[g] = pin_direction_bit_reg[g];
                        eff_out[g] = pin_value_bit_reg[g];
                        readback[g] = pin_direction_bit_reg[g] ? pin_value_bit_reg[g]
                                                               : sync2_reg[g];
                    end
                end
            end else begin : g_np
                always_comb begin
                    eff_oe[g] = pin_direction_bit_reg[g];
                    eff_out[g] = pin_value_bit_reg[g];
                    readback[g] = pin_direction_bit_reg[g] ? pin_value_bit_reg[g]
                                                           : sync2_reg[g];
                end
            end
        end
    endgenerate

    assign pin_o = eff_out;
    assign pin_oe_o = eff_oe;
    // branch sees the pin level while input, else driven level
    assign branch_condition_input_o = readback[gpt_pkg::GPT_BRANCH_PIN];

    always_comb begin
        timer_output_select_next = timer_output_select_reg;
        pin_direction_bit_next = pin_direction_bit_reg;
        pin_value_bit_next = pin_value_bit_reg;
        rdata_next = rdata_reg;
        if (bus_i.wr && hit) begin
            timer_output_select_next = bus_i.wdata[gpt_pkg::GPT_SEL_BIT];
            pin_direction_bit_next =
                bus_i.wdata[gpt_pkg::GPT_DIR_LSB +: NPINS];
            pin_value_bit_next = bus_i.wdata[gpt_pkg::GPT_DAT_LSB +: NPINS];
        end
        if (bus_i.rd) begin
            rdata_next = 16'h0000;
            if (hit) begin
                rdata_next[gpt_pkg::GPT_SEL_BIT] = timer_output_select_reg;
                rdata_next[gpt_pkg::GPT_DIR_LSB +: NPINS] = pin_direction_bit_reg;
                rdata_next[gpt_pkg::GPT_DAT_LSB +: NPINS] = readback;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_output_select_reg <= gpt_pkg::GPT_SEL_RST;
            pin_direction_bit_reg <= gpt_pkg::GPT_DIR_RST;
            pin_value_bit_reg <= gpt_pkg::GPT_DAT_RST;
            rdata_reg <= 16'h0000;
        end else begin
            timer_output_select_reg <= timer_output_select_next;
            pin_direction_bit_reg <= pin_direction_bit_next;
            pin_value_bit_reg <= pin_value_bit_next;
            rdata_reg <= rdata_next;
        end
    end

    assign rdata_o = rdata_reg;
endmodule : gpt_port

// *** tb/gpt_board.sv ***
// board logic facing the four general pins
`timescale 1ns/100ps
module gpt_board (
    input wire logic [3:0] oe_i,
    input wire logic [3:0] drv_i,
    input wire logic [3:0] ext_i,
    output logic [3:0] lvl_o
);
    assign lvl_o = (oe_i & drv_i) | (~oe_i & ext_i);
endmodule : gpt_board

// *** tb/gpt_port_checker.sv ***
// assertions on the general pin port
`timescale 1ns/100ps
module gpt_port_checker #(parameter int NPINS = 4) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire gpt_pkg::gpt_bus_req_t bus_i,
    input wire logic [15:0] rdata_o,
    input wire logic tick_i,
    input wire logic [NPINS-1:0] pin_i,
    input wire logic [NPINS-1:0] pin_o,
    input wire logic [NPINS-1:0] pin_oe_o,
    input wire logic branch_condition_input_o,
    input wire logic timer_irq_o
);
    wire hit = bus_i.addr == gpt_pkg::GPT_CTRL_ADDR;
    wire [2:0] wr_dir = bus_i.wdata[10:8];
    wire [3:0] wr_dat = bus_i.wdata[3:0];
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_dir;
        bus_i.wr && hit |=> pin_oe_o[2:0] == $past(wr_dir);
    endproperty
    property p_drv;
        bus_i.wr && hit |=> ((pin_o ^ $past(wr_dat)) & pin_oe_o & 4'h7) == 4'h0;
    endproperty
    a_dir_oe: assert property (p_dir) else $error("enable");
    a_dat_pin: assert property (p_drv) else $error("drive");
    a_rsvd_zero: assert property ($past(bus_i.rd) |-> (rdata_o & 16'h70F0) == 16'h0000)
        else $error("reserved");
    a_unmap_rd: assert property (bus_i.rd && !hit |=> rdata_o == 16'h0000)
        else $error("unmapped");
    a_rd_hold: assert property (!$past(bus_i.rd) && !$past(rst_i) |-> $stable(rdata_o))
        else $error("hold");
    a_branch_pin: assert property ((!pin_oe_o[2] && $stable(pin_i[2]))[*4]
        |-> branch_condition_input_o == pin_i[2]) else $error("branch");
    a_irq_tick: assert property (timer_irq_o |-> $past(tick_i)) else $error("tick");
    a_irq_once: assert property (timer_irq_o |=> !timer_irq_o) else $error("irq");
    c_irq: cover property (timer_irq_o);
    c_pin3: cover property (pin_oe_o[3] && pin_o[3]);
    c_read: cover property (bus_i.rd && hit);
endmodule : gpt_port_checker

bind gpt_port gpt_port_checker #(.NPINS(NPINS)) u_chk (.clk_i, .rst_i, .bus_i, .rdata_o,
    .tick_i, .pin_i, .pin_o, .pin_oe_o, .branch_condition_input_o, .timer_irq_o);

// *** tb/gpt_port_test.sv ***
// self-checking bench for the general pin port
`timescale 1ns/100ps
module gpt_port_test;
    logic clk_i = 0, rst_i = 1, tick_i = 0, xs = 0, brc, irq, p3 = 0;
    gpt_pkg::gpt_bus_req_t bus_i = '0;
    logic [15:0] rdata_o, m = 0, a, d, e;
    logic [3:0] pin_i, pin_o, pin_oe_o, ext = 0, oe, mo;
    integer seed = 9072, error_cnt = 0, n_compared = 0, irqs = 0, pls = 0;
    gpt_port #(.PERIOD(16'h0004)) DUT (.clk_i, .rst_i, .bus_i, .rdata_o, .tick_i, .pin_i,
        .pin_o, .pin_oe_o, .external_interface_select_pin_i(xs),
        .branch_condition_input_o(brc), .timer_irq_o(irq));
    gpt_board u_board (.oe_i(pin_oe_o), .drv_i(pin_o), .ext_i(ext), .lvl_o(pin_i));
    initial forever #10 clk_i = ~clk_i;
    task automatic cmp(input string nm, input logic [15:0] ev, input logic [15:0] sv);
        n_compared++;
        if (sv !== ev) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, ev, sv);
        end
    endtask : cmp
    task automatic acc(input logic w, input logic [15:0] ad, input logic [15:0] wd);
        @(posedge clk_i);
        bus_i <= '{ad, wd, w, !w};
        @(posedge clk_i);
        bus_i <= '0;
        @(negedge clk_i);
    endtask : acc
    task automatic wrap_up;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        acc(0, 16'h003C, 16'h0000);
        cmp("reset", 16'h0000, rdata_o);
        repeat (40) begin
            a = ($random(seed) & 1) ? 16'h003C : 16'h0042;
            d = $random(seed);
            @(posedge clk_i);
            ext <= d[7:4];
            xs <= d[12];
            acc(1, a, d);
            if (a == 16'h003C) m = d & 16'h8F0F;
            oe = {m[15] ? !xs : m[11], m[10:8]};
            mo = {!m[15] & m[3], m[2:0]};
            e = {m[15], 3'h0, m[11:8], 4'h0, (oe & mo | ~oe & ext) & {!m[15], 3'h7}};
            cmp("enable", oe, pin_oe_o);
            cmp("drive", mo & oe, pin_o & pin_oe_o);
            repeat (3) @(posedge clk_i);
            acc(0, a, 16'h0000);
            cmp("read", a == 16'h003C ? e : 16'h0000, rdata_o);
            cmp("branch", e[2], brc);
        end
        @(posedge clk_i);
        rst_i <= 1;
        repeat (2) @(posedge clk_i);
        rst_i <= 0;
        @(negedge clk_i);
        cmp("reset pins", 16'h0000, {pin_oe_o, pin_o});
        cmp("reset read", 16'h0000, rdata_o);
        acc(1, 16'h003C, 16'h8000);
        @(posedge clk_i);
        xs <= 0;
        tick_i <= 1;
        // first zero after reset count, then every PERIOD+1 steps
        for (int i = 1; i <= 65553; i++) begin
            @(posedge clk_i);
            if (i == 65550) tick_i <= 0;
            @(negedge clk_i);
            irqs += irq;
            pls += pin_o[3] & pin_oe_o[3] & !p3;
            p3 = pin_o[3] & pin_oe_o[3];
        end
        cmp("irqs", 16'h0004, irqs[15:0]);
        cmp("pulses", 16'h0004, pls[15:0]);
        wrap_up;
    end
    initial begin
        repeat (70000) @(posedge clk_i);
        error_cnt++;
        wrap_up;
    end
endmodule : gpt_port_test
